// >>> rsc_reset_source_combiner.sv
// reset source combiner: master reset, cause flags and event interrupt
// Functional notes
// - merge power-on, brownout, pin, instruction, watchdog, trap, opcode.
// - any active source asserts master reset; no source masks another.
// - chosen registers take defined values on reset; others keep data.
// - every reset sets the cause flag matching its kind.
// - power-on clears all cause flags but leaves bit 0 set.
// - software may write each cause flag to one or zero while its source is idle.
// - writing a cause flag never starts a reset.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module rsc_reset_source_combiner
   import rsc_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               sys_rst_i,
   input  wire logic               ext_clear_n_i,
   input  wire logic               brownout_reset_source_i,
   input  wire logic               software_instruction_reset_i,
   input  wire logic               watchdog_timeout_reset_i,
   input  wire logic               trap_conflict_reset_i,
   input  wire logic               illegal_opcode_or_uninit_reg_reset_i,
   input  wire rsc_bus_req_s       bus_i,
   output logic [RSC_DW-1:0]       rdata_o,
   output logic                    master_system_reset_o,
   output logic                    irq_o
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic                ext_act;
   logic                ext_lvl;
   rsc_cause_s          src;
   logic [RSC_NSRC-1:0] src_vec;
   logic [RSC_NSRC-1:0] rise;
   logic [RSC_NSRC-1:0] src_prev_q;
   logic [RSC_NSRC-1:0] cause_q;
   logic [RSC_NSRC-1:0] cause_d;
   logic [RSC_NSRC-1:0] stat_q;
   logic [RSC_NSRC-1:0] stat_d;
   logic [RSC_NSRC-1:0] mask_q;
   logic [RSC_NSRC-1:0] mask_d;
   logic [RSC_DW-1:0]   scratch_q;
   logic [RSC_DW-1:0]   scratch_d;
   logic [RSC_DW-1:0]   rdata_q;
   logic [RSC_DW-1:0]   rdata_d;
   logic                mrst_q;
   logic                mrst_d;
   logic                wr_cause;
   logic                wr_stat;
   logic                wr_mask;
   logic                wr_scratch;

   // ------------------------------------------------------------------
   // source gathering
   // ------------------------------------------------------------------
   // the clear pin is asynchronous to clk_i, so it is filtered first
   rsc_pin_sync u_pin_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (ext_clear_n_i),
      .level_o   (ext_lvl)
   );

   assign ext_act = ~ext_lvl;

   // power-on acts through the async reset itself, so its live bit is 0
   always_comb
   begin
      src          = '0;
      src.por      = 1'b0;
      src.brownout = brownout_reset_source_i;
      src.ext      = ext_act;
      src.sw_instr = software_instruction_reset_i;
      src.watchdog = watchdog_timeout_reset_i;
      src.trap     = trap_conflict_reset_i;
      src.iop      = illegal_opcode_or_uninit_reg_reset_i;
   end

   assign src_vec = src;
   assign rise    = src_vec & ~src_prev_q;

   // ------------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------------
   assign wr_cause   = bus_i.wr && (bus_i.addr == RSC_OFS_CAUSE);
   assign wr_stat    = bus_i.wr && (bus_i.addr == RSC_OFS_IRQ_STAT);
   assign wr_mask    = bus_i.wr && (bus_i.addr == RSC_OFS_IRQ_MASK);
   assign wr_scratch = bus_i.wr && (bus_i.addr == RSC_OFS_SCRATCH);

   // ------------------------------------------------------------------
   // master reset
   // ------------------------------------------------------------------
   // driven by sources only; register writes have no path here
   always_comb
   begin
      mrst_d = |src_vec;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         mrst_q     <= 1'b1;
         src_prev_q <= '0;
      end
      else
      begin
         mrst_q     <= mrst_d;
         src_prev_q <= src_vec;
      end
   end

   assign master_system_reset_o = mrst_q | sys_rst_i;

   // ------------------------------------------------------------------
   // cause flags
   // ------------------------------------------------------------------
   // a live source beats a software clear in the same cycle
   always_comb
   begin
      cause_d = cause_q;
      if (wr_cause)
      begin
         cause_d = bus_i.wdata[RSC_NSRC-1:0];
      end
      cause_d = cause_d | src_vec;
   end

   // of the resets, only power-on clears this register
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         cause_q <= RSC_CAUSE_POR_RST;
      end
      else
      begin
         cause_q <= cause_d;
      end
   end

   // ------------------------------------------------------------------
   // event interrupt
   // ------------------------------------------------------------------
   always_comb
   begin
      stat_d = stat_q;
      if (wr_stat)
      begin
         stat_d = stat_d & ~bus_i.wdata[RSC_NSRC-1:0];
      end
      stat_d = stat_d | rise;
   end

   // mask is the block's designated register: every reset defines it
   always_comb
   begin
      mask_d = mask_q;
      if (wr_mask)
      begin
         mask_d = bus_i.wdata[RSC_NSRC-1:0];
      end
      if (mrst_q)
      begin
         mask_d = RSC_IRQ_MASK_RST;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         stat_q <= RSC_IRQ_STAT_RST;
         mask_q <= RSC_IRQ_MASK_RST;
      end
      else
      begin
         stat_q <= stat_d;
         mask_q <= mask_d;
      end
   end

   assign irq_o = |(stat_q & mask_q);

   // ------------------------------------------------------------------
   // scratch word
   // ------------------------------------------------------------------
   // no reset on purpose: survives every reset, undefined after power-on
   always_comb
   begin
      scratch_d = scratch_q;
      if (wr_scratch)
      begin
         scratch_d = bus_i.wdata;
      end
   end

   always_ff @(posedge clk_i)
   begin
      scratch_q <= scratch_d;
   end

   // ------------------------------------------------------------------
   // read port
   // ------------------------------------------------------------------
   always_comb
   begin
      rdata_d = RSC_RDATA_RST;
      if (bus_i.rd)
      begin
         unique case (bus_i.addr)
            RSC_OFS_CAUSE:
            begin
               rdata_d[RSC_NSRC-1:0] = cause_q;
            end
            RSC_OFS_IRQ_STAT:
            begin
               rdata_d[RSC_NSRC-1:0] = stat_q;
            end
            RSC_OFS_IRQ_MASK:
            begin
               rdata_d[RSC_NSRC-1:0] = mask_q;
            end
            RSC_OFS_SCRATCH:
            begin
               rdata_d = scratch_q;
            end
            default:
            begin
               rdata_d = RSC_RDATA_RST;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         rdata_q <= RSC_RDATA_RST;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata_o = rdata_q;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking

   default disable iff (sys_rst_i);

   chk_watchdog_merged: assert property (
      watchdog_timeout_reset_i |=> master_system_reset_o)
      else $error("watchdog source did not reach master reset");

   chk_mrst_any_src: assert property (
      (src_vec != '0) |=> mrst_q ##0 (cause_q & $past(src_vec))
                                      == $past(src_vec))
      else $error("active source not seen on master reset");

   chk_mask_defined: assert property (
      mrst_q |=> (mask_q == RSC_IRQ_MASK_RST))
      else $error("mask not defined after reset");

   // a software write right after the event may legally clear the flag
   chk_cause_watchdog_set: assert property (
      $rose(watchdog_timeout_reset_i) ##1 !wr_cause |->
         cause_q[RSC_BIT_WATCHDOG] [*2])
      else $error("watchdog cause flag not set");

   chk_por_cause_only: assert property (
      $past(sys_rst_i) |-> (cause_q == RSC_CAUSE_POR_RST))
      else $error("power-on left other cause flags");

   chk_cause_written: assert property (
      (wr_cause && src_vec == '0) |=>
         (cause_q == $past(bus_i.wdata[RSC_NSRC-1:0])))
      else $error("cause write not retained");

   chk_write_no_reset: assert property (
      (wr_cause && src_vec == '0) |=> !mrst_q)
      else $error("cause write started a reset");

   chk_multi_src_set: assert property (
      (src.brownout && src.trap) |=>
         (cause_q[RSC_BIT_BROWNOUT] && cause_q[RSC_BIT_TRAP]))
      else $error("simultaneous sources not all flagged");

   cov_multi_src: cover property (
      software_instruction_reset_i && watchdog_timeout_reset_i);

   cov_pin_reset: cover property ($rose(ext_act) ##1 mrst_q);

   cov_cause_clear: cover property (
      wr_cause && bus_i.wdata == '0 ##1 cause_q == '0);

   cov_irq: cover property ($rose(irq_o));

endmodule : rsc_reset_source_combiner

// >>> rsc_pkg.sv
// shared constants and types of the reset source combiner
package rsc_pkg;

   // ------------------------------------------------------------------
   // widths
   // ------------------------------------------------------------------
   localparam int unsigned RSC_AW   = 4;
   localparam int unsigned RSC_DW   = 16;
   localparam int unsigned RSC_NSRC = 7;

   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [RSC_AW-1:0] RSC_OFS_CAUSE    = 4'h0;
   localparam logic [RSC_AW-1:0] RSC_OFS_IRQ_STAT = 4'h1;
   localparam logic [RSC_AW-1:0] RSC_OFS_IRQ_MASK = 4'h2;
   localparam logic [RSC_AW-1:0] RSC_OFS_SCRATCH  = 4'h3;

   // ------------------------------------------------------------------
   // bit positions of the cause layout, shared by all three registers
   // ------------------------------------------------------------------
   localparam int unsigned RSC_BIT_POR      = 0;
   localparam int unsigned RSC_BIT_BROWNOUT = 1;
   localparam int unsigned RSC_BIT_EXT      = 2;
   localparam int unsigned RSC_BIT_SW_INSTR = 3;
   localparam int unsigned RSC_BIT_WATCHDOG = 4;
   localparam int unsigned RSC_BIT_TRAP     = 5;
   localparam int unsigned RSC_BIT_IOP      = 6;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [RSC_NSRC-1:0] RSC_CAUSE_POR_RST = 7'h01;
   localparam logic [RSC_NSRC-1:0] RSC_IRQ_STAT_RST  = 7'h00;
   localparam logic [RSC_NSRC-1:0] RSC_IRQ_MASK_RST  = 7'h00;
   localparam logic [RSC_DW-1:0]   RSC_RDATA_RST     = 16'h0000;
   localparam logic                RSC_PIN_IDLE      = 1'b1;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic iop;
      logic trap;
      logic watchdog;
      logic sw_instr;
      logic ext;
      logic brownout;
      logic por;
   } rsc_cause_s;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [RSC_AW-1:0] addr;
      logic [RSC_DW-1:0] wdata;
   } rsc_bus_req_s;

endpackage : rsc_pkg

// >>> rsc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module rsc_pin_sync
   import rsc_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic pin_i,
   output logic      level_o
);

   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;
   logic lvl_d;

   // ------------------------------------------------------------------
   // filter
   // ------------------------------------------------------------------
   // the output moves only once stages two and three agree
   always_comb
   begin
      lvl_d = lvl_q;
      if (s2_q == s3_q)
      begin
         lvl_d = s3_q;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         s1_q  <= RSC_PIN_IDLE;
         s2_q  <= RSC_PIN_IDLE;
         s3_q  <= RSC_PIN_IDLE;
         lvl_q <= RSC_PIN_IDLE;
      end
      else
      begin
         s1_q  <= pin_i;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level_o = lvl_q;

endmodule : rsc_pin_sync

// >>> rsc_reset_source_combiner_tb.sv
// self-checking testbench of the reset source combiner
`timescale 1ns/1ps
module rsc_reset_source_combiner_tb
   import rsc_pkg::*;
;
   logic              clk_i     = 1'b0;
   logic              sys_rst_i = 1'b1;
   logic [6:0]        src_q     = 7'h00;
   rsc_bus_req_s      bus_q     = '0;
   logic [RSC_DW-1:0] rdata;
   logic              mrst;
   logic              irq;
   int                mismatches = 0;
   int                n_tests    = 0;
   int                cyc        = 0;

   always #12.5 clk_i = ~clk_i;

   // bit 0 has no pin: power-on comes from sys_rst_i
   rsc_reset_source_combiner dut_u (
      .clk_i                               (clk_i),
      .sys_rst_i                           (sys_rst_i),
      .ext_clear_n_i                       (~src_q[2]),
      .brownout_reset_source_i             (src_q[1]),
      .software_instruction_reset_i        (src_q[3]),
      .watchdog_timeout_reset_i            (src_q[4]),
      .trap_conflict_reset_i               (src_q[5]),
      .illegal_opcode_or_uninit_reg_reset_i(src_q[6]),
      .bus_i                               (bus_q),
      .rdata_o                             (rdata),
      .master_system_reset_o               (mrst),
      .irq_o                               (irq)
   );

   // ------------------------------------------------------------------
   // verdict, compare and bus tasks
   // ------------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wr(logic [RSC_AW-1:0] a, logic [15:0] d);
      @(posedge clk_i);
      bus_q.wr    <= 1'b1;
      bus_q.addr  <= a;
      bus_q.wdata <= d;
      @(posedge clk_i);
      bus_q.wr    <= 1'b0;
   endtask : wr

   // data stand only in the cycle after the strobe, zero afterwards
   task automatic rd_chk(logic [RSC_AW-1:0] a, logic [15:0] e, string n);
      @(posedge clk_i);
      bus_q.rd   <= 1'b1;
      bus_q.addr <= a;
      @(posedge clk_i);
      bus_q.rd   <= 1'b0;
      #1;
      chk(n, e, rdata);
      @(posedge clk_i);
      #1;
      chk("rdata idle", 16'h0000, rdata);
   endtask : rd_chk

   // hold long enough for the filtered pin path, then wait for release
   task automatic fire(logic [6:0] m);
      int k;
      @(posedge clk_i);
      src_q <= m;
      repeat (7) @(posedge clk_i);
      src_q <= 7'h00;
      #1;
      chk("reset asserted", 16'h0001, {15'h0, mrst});
      k = 0;
      while (mrst !== 1'b0 && k < 20)
      begin
         @(posedge clk_i);
         #1;
         k++;
      end
      chk("reset released", 16'h0000, {15'h0, mrst});
   endtask : fire

   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         mismatches++;
         print_verdict();
      end
   end

   // ------------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------------
   initial
   begin
      repeat (11) @(posedge clk_i);
      #1;
      chk("reset in por", 16'h0001, {15'h0, mrst});
      @(posedge clk_i);
      sys_rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd_chk(RSC_OFS_CAUSE, 16'h0001, "cause por");
      rd_chk(RSC_OFS_IRQ_STAT, 16'h0000, "stat por");
      rd_chk(RSC_OFS_IRQ_MASK, 16'h0000, "mask por");
      rd_chk(4'hf, 16'h0000, "unmapped");
      wr(RSC_OFS_SCRATCH, 16'ha5c3);
      $display("test power-on done");

      for (int i = 1; i < 7; i++)
      begin
         wr(RSC_OFS_CAUSE, 16'h0000);
         fire(7'(1) << i);
         rd_chk(RSC_OFS_CAUSE, 16'(1) << i, "cause one");
      end
      rd_chk(RSC_OFS_SCRATCH, 16'ha5c3, "scratch kept");
      $display("test single sources done");

      wr(RSC_OFS_CAUSE, 16'h0000);
      fire(7'h3a);
      rd_chk(RSC_OFS_CAUSE, 16'h003a, "cause multi");
      $display("test simultaneous done");

      wr(RSC_OFS_CAUSE, 16'h007f);
      repeat (4) @(posedge clk_i);
      #1;
      chk("no sw reset", 16'h0000, {15'h0, mrst});
      rd_chk(RSC_OFS_CAUSE, 16'h007f, "cause set");
      wr(RSC_OFS_CAUSE, 16'h0005);
      rd_chk(RSC_OFS_CAUSE, 16'h0005, "cause mix");
      $display("test software access done");

      rd_chk(RSC_OFS_IRQ_STAT, 16'h007e, "stat sticky");
      chk("irq masked", 16'h0000, {15'h0, irq});
      wr(RSC_OFS_IRQ_MASK, 16'h0010);
      #1;
      chk("irq on", 16'h0001, {15'h0, irq});
      wr(RSC_OFS_IRQ_STAT, 16'h0010);
      #1;
      chk("irq cleared", 16'h0000, {15'h0, irq});
      rd_chk(RSC_OFS_IRQ_STAT, 16'h006e, "stat w1c");
      wr(RSC_OFS_IRQ_STAT, 16'h006e);
      fire(7'h10);
      rd_chk(RSC_OFS_IRQ_MASK, 16'h0000, "mask on reset");
      rd_chk(RSC_OFS_IRQ_STAT, 16'h0010, "stat event");
      wr(RSC_OFS_IRQ_MASK, 16'h0010);
      #1;
      chk("irq event", 16'h0001, {15'h0, irq});
      $display("test interrupt done");

      wr(RSC_OFS_CAUSE, 16'h007e);
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd_chk(RSC_OFS_CAUSE, 16'h0001, "cause second por");
      rd_chk(RSC_OFS_SCRATCH, 16'ha5c3, "scratch por");
      chk("irq after por", 16'h0000, {15'h0, irq});
      $display("test second power-on done");
      print_verdict();
   end

endmodule : rsc_reset_source_combiner_tb
